// ==== rtl/gst_pkg.sv ====
// Package for the gated sixteen bit timer: register map, fields, types
package gst_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hc;
  // Control field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GATE_EN_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_TOGGLE_BIT = 3;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_SYNC_BIT = 6;
  localparam int CTRL_EXTCLK_BIT = 7;
  localparam int CTRL_GVAL_BIT = 8;
  // Status bit positions
  localparam int STAT_OVF_BIT = 0;
  // Reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // Gate source codes
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_BYTE_OVF = 2'h1;
  localparam logic [1:0] SRC_PERIOD = 2'h2;
  // Compare mode that resets the timer
  localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hb;

  // Compare unit event bundle
  typedef struct packed {
    logic [3:0] compare_mode_select;
    logic match;
  } gst_cmp_t;

  // Control settings
  typedef struct packed {
    logic ext_clk;
    logic sync;
    logic [1:0] gate_source_select;
    logic gate_toggle_enable;
    logic gate_polarity;
    logic gate_enable;
    logic on;
  } gst_ctrl_t;
endpackage

// ==== rtl/gst_timer.sv ====
// Gated sixteen bit timer with Avalon-MM register slave
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Sixteen bit count wraps from all-ones to zero
// - Wrap sets sticky flag; enable gates interrupt
// - Special event compare mode resets the counter
// - Reset only guaranteed in timer/synchronous modes
// - Software count write beats special event reset
// - Special event reset never sets overflow flag
// - Unit two event also starts enabled conversion
// - Gating only when gate enable bit set
// - Count while gate active, hold otherwise
// - Polarity zero counts low, one counts high
// - Selector picks pin, byte overflow, period match
// - Byte timer wrap yields internal gate pulse
// - Period match pulse high one cycle
// - Period source counts one cycle or all but one
// - Toggle flop inverts per edge, acts as gate
// - Toggle flop held zero while toggle disabled
// - Gate value status shows toggled gate counting, else gate active
module gst_timer (
  input wire logic core_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Pins and neighbours
  input wire logic gate_pin,
  input wire logic counter_clock,
  input wire logic [7:0] byte_timer,
  input wire logic [7:0] period_timer_count,
  input wire logic [7:0] period_timer_limit,
  input wire gst_pkg::gst_cmp_t compare_unit_one,
  input wire gst_pkg::gst_cmp_t compare_unit_two,
  input wire logic adc_enabled,
  output logic adc_start,
  output logic irq
);
  gst_pkg::gst_ctrl_t ctrl_ff;
  logic [15:0] count_ff;
  logic ovf_flag_ff;
  logic ovf_mask_ff;
  logic toggle_ff;
  logic gval_ff;
  logic pin_meta_ff, pin_sync_ff;
  logic clk_meta_ff, clk_sync_ff, clk_prev_ff;
  logic [7:0] byte_prev_ff;
  logic [7:0] ptc_prev_ff;
  logic ptc_match_ff;
  logic period_pulse_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0] resp_ff;
  logic byte_pulse;
  logic gate_raw;
  logic gate_pol;
  logic gate_active;
  logic tick;
  logic inc;
  logic wrap;
  logic sev_one, sev_two, sev_reset;
  logic wr_count;
  logic wr_access;
  logic hit;
  logic [15:0] wmask;

  // Byte lanes into a 16-bit mask
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // True when a compare unit asks for a special event this cycle
  function automatic logic sev(input gst_pkg::gst_cmp_t c);
    sev = c.match && (c.compare_mode_select == gst_pkg::CMP_SPECIAL_EVENT);
  endfunction

  // Bus handshake: one wait cycle then acknowledge; a write lands on the acknowledging edge
  assign wr_access = avs_write && ack_ff;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata = rdata_ff;
  assign avs_response = resp_ff;
  assign hit = (avs_address == gst_pkg::ADDR_CTRL) || (avs_address == gst_pkg::ADDR_COUNT) ||
               (avs_address == gst_pkg::ADDR_STATUS) || (avs_address == gst_pkg::ADDR_MASK);
  assign wmask = lane_mask(avs_byteenable);
  assign wr_count = wr_access && (avs_address == gst_pkg::ADDR_COUNT);

  // Pin and external clock synchronisers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      clk_meta_ff <= 1'b0;
      clk_sync_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= gate_pin;
      pin_sync_ff <= pin_meta_ff;
      clk_meta_ff <= counter_clock;
      clk_sync_ff <= clk_meta_ff;
      clk_prev_ff <= clk_sync_ff;
    end
  end

  // Neighbour timer history for wrap and reset-after-match detection
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      byte_prev_ff <= 8'h00;
      ptc_prev_ff <= 8'h00;
      ptc_match_ff <= 1'b0;
      period_pulse_ff <= 1'b0;
    end else begin
      byte_prev_ff <= byte_timer;
      ptc_prev_ff <= period_timer_count;
      ptc_match_ff <= (period_timer_count == period_timer_limit);
      // High one cycle when the period timer returns to zero after a match
      period_pulse_ff <= ptc_match_ff && (period_timer_count == 8'h00)
                         && (ptc_prev_ff != 8'h00);
    end
  end

  // Wrap from all-ones to zero of the byte timer
  assign byte_pulse = (byte_prev_ff == 8'hff) && (byte_timer == 8'h00);

  // Gate source mux; reserved code keeps gate inactive
  always_comb begin
    case (ctrl_ff.gate_source_select)
      gst_pkg::SRC_PIN: gate_raw = pin_sync_ff;
      gst_pkg::SRC_BYTE_OVF: gate_raw = byte_pulse;
      gst_pkg::SRC_PERIOD: gate_raw = period_pulse_ff;
      default: gate_raw = ctrl_ff.gate_polarity ? 1'b0 : 1'b1;
    endcase
  end

  // Polarity: level one means count
  assign gate_pol = ctrl_ff.gate_polarity ? gate_raw : ~gate_raw;

  // Toggle flop swaps on each active-going edge of the polarised gate
  logic gate_pol_prev_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      toggle_ff <= 1'b0;
      gate_pol_prev_ff <= 1'b0;
    end else begin
      gate_pol_prev_ff <= gate_pol;
      if (!ctrl_ff.gate_toggle_enable) begin
        toggle_ff <= 1'b0;
      end else if (gate_pol && !gate_pol_prev_ff) begin
        toggle_ff <= ~toggle_ff;
      end
    end
  end

  // Effective gate level; reserved selector in toggle mode also holds
  assign gate_active = (ctrl_ff.gate_source_select == 2'h3) ? 1'b0 :
                       (ctrl_ff.gate_toggle_enable ? toggle_ff : gate_pol);

  // Count tick: every cycle internally, rising edge of external clock otherwise
  assign tick = ctrl_ff.ext_clk ? (clk_sync_ff && !clk_prev_ff) : 1'b1;
  assign inc = ctrl_ff.on && tick && (!ctrl_ff.gate_enable || gate_active);
  assign wrap = inc && (count_ff == gst_pkg::COUNT_MAX);

  // Special event triggers; reset ignored in asynchronous counter mode
  assign sev_one = sev(compare_unit_one);
  assign sev_two = sev(compare_unit_two);
  assign sev_reset = (sev_one || sev_two) &&
                     (!ctrl_ff.ext_clk || ctrl_ff.sync);

  // Counter: software write wins, then special event, then increment
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_ff <= gst_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_ff <= (count_ff & ~wmask) | (avs_writedata[15:0] & wmask);
    end else if (sev_reset) begin
      count_ff <= gst_pkg::COUNT_RST;
    end else if (inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Overflow flag: set wins over write-one-to-clear; trigger never sets it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ovf_flag_ff <= 1'b0;
    end else if (wrap && !wr_count && !sev_reset) begin
      ovf_flag_ff <= 1'b1;
    end else if (wr_access && avs_address == gst_pkg::ADDR_STATUS && avs_byteenable[0]
                 && avs_writedata[gst_pkg::STAT_OVF_BIT]) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  // Interrupt level: flag gated by enable
  assign irq = ovf_flag_ff && ovf_mask_ff;

  // Conversion start pulse from unit two
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= sev_two && adc_enabled;
    end
  end

  // Gate value status: toggled gate active and counting in toggle mode, effective gate level otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gval_ff <= 1'b0;
    end else begin
      gval_ff <= ctrl_ff.gate_toggle_enable ? (toggle_ff && inc) : gate_active;
    end
  end

  // Control and mask registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctrl_ff <= gst_pkg::CTRL_RST;
      ovf_mask_ff <= 1'b0;
    end else if (wr_access && avs_byteenable[0]) begin
      if (avs_address == gst_pkg::ADDR_CTRL) begin
        ctrl_ff <= avs_writedata[7:0];
      end
      if (avs_address == gst_pkg::ADDR_MASK) begin
        ovf_mask_ff <= avs_writedata[gst_pkg::STAT_OVF_BIT];
      end
    end
  end

  // Bus answer: data and response registered in the waited cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 2'h0;
    end else begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      if ((avs_read || avs_write) && !ack_ff) begin
        resp_ff <= hit ? 2'h0 : 2'h3; // Unmapped gives decode error
        rdata_ff <= 32'h0000_0000;
        if (avs_read) begin
          case (avs_address)
            gst_pkg::ADDR_CTRL: rdata_ff <= {23'h0, gval_ff, ctrl_ff};
            gst_pkg::ADDR_COUNT: rdata_ff <= {16'h0000, count_ff};
            gst_pkg::ADDR_STATUS: rdata_ff <= {31'h0, ovf_flag_ff};
            gst_pkg::ADDR_MASK: rdata_ff <= {31'h0, ovf_mask_ff};
            default: rdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule // gst_timer

`default_nettype wire

// ==== verif/gst_timer_monitor.sv ====
// Checker for the gated timer bus, interrupt and conversion start
`timescale 1ns/10ps
`default_nettype none
module gst_timer_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire gst_pkg::gst_cmp_t compare_unit_two,
  input wire logic adc_enabled,
  input wire logic adc_start,
  input wire logic irq
);
  logic req, trig, mwr, mask_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Pin-level views of a request, a conversion trigger and a mask write
  assign req = avs_read || avs_write;
  assign trig = compare_unit_two.match && adc_enabled
    && compare_unit_two.compare_mode_select == gst_pkg::CMP_SPECIAL_EVENT;
  assign mwr = avs_write && !avs_waitrequest && avs_address == gst_pkg::ADDR_MASK;
  // Mask shadow, since the register itself is hidden behind the bus
  always_ff @(posedge core_clk) begin
    if (!rst_b) mask_ff <= 1'b0;
    else if (mwr) mask_ff <= avs_writedata[0];
  end
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("slow");
  a_wait_idle: assert property (!req |-> !avs_waitrequest) else $error("idle wait");
  a_data_stands: assert property (avs_waitrequest |-> $stable(avs_readdata)
    && $stable(avs_response)) else $error("answer moved");
  a_resp_code: assert property (avs_read && !avs_waitrequest |-> avs_response
    == (avs_address[1:0] == 2'h0 ? 2'h0 : 2'h3)) else $error("bad response");
  a_adc_start: assert property (trig |=> adc_start) else $error("no start");
  a_adc_cause: assert property (adc_start |-> $past(trig)) else $error("stray start");
  a_irq_masked: assert property (!mask_ff |-> !irq) else $error("masked irq");
  c_adc: cover property (adc_start);
  c_irq: cover property (irq);
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0);
endmodule // gst_timer_monitor
bind gst_timer gst_timer_monitor i_gst_timer_monitor (.core_clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response,
  .compare_unit_two, .adc_enabled, .adc_start, .irq);
`default_nettype wire

// ==== verif/gst_neighbours.sv ====
// Neighbour timers: free byte timer and period timer
`timescale 1ns/10ps
`default_nettype none
module gst_neighbours (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] period_timer_limit,
  output logic [7:0] byte_timer,
  output logic [7:0] period_timer_count
);
  // Byte timer wraps ff to 00; period timer clears the cycle after a match
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      byte_timer <= 8'h00;
      period_timer_count <= 8'h00;
    end else begin
      byte_timer <= byte_timer + 8'h01;
      period_timer_count <= (period_timer_count == period_timer_limit) ? 8'h00
        : period_timer_count + 8'h01;
    end
  end
endmodule // gst_neighbours
`default_nettype wire

// ==== verif/gst_timer_test.sv ====
// Self-checking bench for the gated timer
`timescale 1ns/10ps
`default_nettype none
module gst_timer_test;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, adc_start, irq;
  logic [1:0] avs_response;
  logic gate_pin = 1'b0;
  logic adc_enabled = 1'b0;
  logic [7:0] byte_timer, period_timer_count;
  logic [7:0] period_timer_limit = 8'h03;
  gst_pkg::gst_cmp_t compare_unit_one = '0;
  gst_pkg::gst_cmp_t compare_unit_two = '0;
  int checks = 0;
  int fail_count = 0;
  gst_timer i_gst_timer (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response,
    .gate_pin, .counter_clock(1'b0), .byte_timer, .period_timer_count, .period_timer_limit,
    .compare_unit_one, .compare_unit_two, .adc_enabled, .adc_start, .irq);
  gst_neighbours i_gst_neighbours (.core_clk, .rst_b, .period_timer_limit, .byte_timer,
    .period_timer_count);
  // Core clock, 25 ns period
  always #12.5 core_clk = ~core_clk;
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One bus cycle; the spare edge at the end keeps back-to-back calls race free
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) fail_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rchk(input string w, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask
  // Count from zero under one setting, then freeze via the reserved source
  task automatic win(input logic [31:0] c, input int cyc, input int lo, input int hi);
    bus(1'b1, gst_pkg::ADDR_COUNT, 32'h0);
    bus(1'b1, gst_pkg::ADDR_CTRL, c);
    repeat (cyc) @(posedge core_clk);
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h33);
    bus(1'b0, gst_pkg::ADDR_COUNT, 32'h0);
    check("count", {31'h0, rd >= lo && rd <= hi}, 32'h1);
  endtask
  task automatic pulse;
    compare_unit_one <= '{gst_pkg::CMP_SPECIAL_EVENT, 1'b1};
    compare_unit_two <= '{gst_pkg::CMP_SPECIAL_EVENT, 1'b1};
    @(posedge core_clk);
    compare_unit_one <= '0;
    compare_unit_two <= '0;
  endtask
  task automatic t_reset;
    // Pin low with polarity zero reads as an active gate in the status bit
    rchk("ctrl", gst_pkg::ADDR_CTRL, 32'h100);
    rchk("count", gst_pkg::ADDR_COUNT, 32'h0);
    rchk("status", gst_pkg::ADDR_STATUS, 32'h0);
    rchk("unmapped", 4'h2, 32'h0);
  endtask
  task automatic t_irq;
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h33);
    bus(1'b1, gst_pkg::ADDR_COUNT, 32'hfffe);
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h01);
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h33);
    bus(1'b0, gst_pkg::ADDR_COUNT, 32'h0);
    check("wrap", {24'h0, rd[15:8]}, 32'h0);
    rchk("flag", gst_pkg::ADDR_STATUS, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, gst_pkg::ADDR_MASK, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, gst_pkg::ADDR_STATUS, 32'h1);
    rchk("clear", gst_pkg::ADDR_STATUS, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
  endtask
  // Async counting ignores the event; a coinciding write wins over it
  task automatic t_event;
    adc_enabled <= 1'b1;
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h81);
    bus(1'b1, gst_pkg::ADDR_COUNT, 32'h0500);
    pulse();
    rchk("async", gst_pkg::ADDR_COUNT, 32'h0500);
    bus(1'b1, gst_pkg::ADDR_CTRL, 32'h33);
    // Event placed in the cycle whose edge also lands the write
    fork
      bus(1'b1, gst_pkg::ADDR_COUNT, 32'h0700);
      begin
        @(posedge core_clk);
        pulse();
      end
    join
    rchk("write", gst_pkg::ADDR_COUNT, 32'h0700);
    pulse();
    rchk("event", gst_pkg::ADDR_COUNT, 32'h0);
    rchk("noflag", gst_pkg::ADDR_STATUS, 32'h0);
  endtask
  task automatic t_gate;
    win(32'h07, 0, 0, 0);
    win(32'h03, 0, 1, 8);
    win(32'h05, 0, 1, 8);
    win(32'h37, 0, 0, 0);
    gate_pin <= 1'b1;
    win(32'h07, 0, 1, 8);
    win(32'h03, 0, 0, 0);
    win(32'h17, 520, 2, 3);
    win(32'h27, 40, 10, 12);
    win(32'h23, 40, 31, 34);
    win(32'h2f, 40, 19, 24);
    rchk("ctrl", gst_pkg::ADDR_CTRL, 32'h33);
  endtask
  // Main sequence; reset held low for two edges
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_irq();
    t_event();
    t_gate();
    conclude();
  end
  // Watchdog, about five times the expected run
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // gst_timer_test
`default_nettype wire
